// ### design/acp_top.sv
// Correction curve store, serial command parser and altitude reporter.
// Function
// - One correction per 1000 ft, none below zero
// - Lowest correction point is zero feet
// - Corrections referenced to whole mark, not transition
// - Parallel code steps 50 ft before mark
// - Program trigger stores correction at selected altitude
// - Up press then two-second down hold clears
// - Serial link 9600 baud, 8N1, no flow
// - Altitude streamed unrequested at 10 ft resolution
// - Bare terminator answers prompt and current altitude
// - Correction-entry command answers correction prompt
// - No backspace; abort key discards partial command
// - Set-altitude stores correction, echoes mark altitude
// - Abort twice returns to normal streaming
// - Dump lists corrections as indexed three-digit table
`timescale 1ns/1ps
module acp_top
  import acp_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int CLR_CYC_P = CLR_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ser_rx,
  output logic                          ser_tx,
  input  wire logic signed [ALT_W-1:0]  press_alt_ft,
  input  wire logic                     program_trigger,
  input  wire logic [4:0]               prog_alt_kft,
  input  wire logic                     up_program,
  input  wire logic                     down_hold,
  output logic signed [CODE_W-1:0]      par_alt_code,
  output logic                          cmd_mode
);
  function automatic logic [ALT_W-1:0] udiv(input logic [ALT_W-1:0] n,
                                            input logic [ALT_W-1:0] d);
    logic [ALT_W:0]   r;
    logic [ALT_W-1:0] q;
    r = '0;
    q = '0;
    for (int i = ALT_W - 1; i >= 0; i--) begin
      r = {r[ALT_W-1:0], n[i]};
      if (r >= {1'b0, d}) begin
        r    = r - {1'b0, d};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  function automatic logic [7:0] dig_ch(input logic [ALT_W-1:0] v, input logic [2:0] p);
    logic [ALT_W-1:0] pw;
    logic [ALT_W-1:0] q;
    pw = ALT_W'(1);
    for (int i = 0; i < 5; i++) begin
      if (3'(i) < p) begin
        pw = ALT_W'(pw * ALT_W'(RADIX));
      end
    end
    q = udiv(v, pw);
    return CH_ZERO + 8'(q - ALT_W'(udiv(q, ALT_W'(RADIX)) * ALT_W'(RADIX)));
  endfunction

  function automatic logic signed [ALT_W:0] mark_ft(input logic [4:0] k);
    return (ALT_W+1)'(k) * (ALT_W+1)'(MARK_FT);
  endfunction

  function automatic logic signed [CORR_W-1:0] clip_corr(input logic signed [ALT_W:0] e);
    if (e > CORR_MAX) begin
      return CORR_W'(CORR_MAX);
    end
    if (e < -CORR_MAX) begin
      return -CORR_W'(CORR_MAX);
    end
    return CORR_W'(e);
  endfunction

  function automatic logic [8:0] msg_len(input acp_msg_t k);
    unique case (k)
      MSG_STREAM: return 9'(LEN_STREAM);
      MSG_PROMPT: return 9'(LEN_PROMPT);
      MSG_CORR:   return 9'(LEN_CORR);
      MSG_ECHO:   return 9'(LEN_ECHO);
      MSG_DUMP:   return 9'(LEN_DUMP);
    endcase
  endfunction

  function automatic logic is_dig(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  logic [7:0] rx_byte;
  logic       rx_vld;
  logic       tx_rdy;
  logic [7:0] tx_ch;

  logic signed [CORR_W-1:0] curve_reg [N_MARKS];
  logic signed [CORR_W-1:0] curve_next [N_MARKS];
  logic                     armed_reg, armed_next;
  logic [31:0]              hold_reg, hold_next;
  logic                     clear_fire;
  acp_mode_t                mode_reg, mode_next;
  logic [7:0]               buf_reg [3];
  logic [7:0]               buf_next [3];
  logic [2:0]               len_reg, len_next;
  logic                     q_last_reg, q_last_next;
  logic                     req_reg, req_next;
  acp_msg_t                 req_kind_reg, req_kind_next;
  logic signed [ALT_W-1:0]  echo_reg, echo_next;
  logic                     set_en;
  logic [4:0]               set_idx;
  logic [6:0]               set_num;
  logic                     busy_reg, busy_next;
  acp_msg_t                 kind_reg, kind_next;
  logic [8:0]               idx_reg, idx_next;
  logic signed [ALT_W-1:0]  snap_reg, snap_next;
  logic                     take;
  logic signed [CODE_W-1:0] code_reg, code_next;
  logic signed [ALT_W-1:0]  corr_alt;
  logic [ALT_W-1:0]         seg;
  logic [ALT_W-1:0]         s_abs;
  logic [ALT_W-1:0]         e_abs;
  logic signed [ALT_W:0]    shifted;
  logic [4:0]               ent;
  logic [8:0]               j;

  acp_uart #(.BIT_CYC_P(BIT_CYC_P)) u_uart (
    .clk      (clk),
    .rst      (rst),
    .rx       (ser_rx),
    .tx       (ser_tx),
    .rx_data  (rx_byte),
    .rx_valid (rx_vld),
    .tx_data  (tx_ch),
    .tx_valid (busy_reg),
    .tx_ready (tx_rdy)
  );

  // Nearest whole mark supplies the correction; negative altitudes get none.
  always_comb begin
    seg      = udiv(ALT_W'(press_alt_ft + ALT_W'(MARK_FT / 2)), ALT_W'(MARK_FT));
    corr_alt = press_alt_ft;
    if (press_alt_ft >= LOW_MARK_FT && seg < N_MARKS) begin
      corr_alt = press_alt_ft + ALT_W'(curve_reg[seg[4:0]]);
    end
    shifted = (ALT_W+1)'(corr_alt) + (ALT_W+1)'(BIAS_FT + TRANS_LEAD_FT);
    if (shifted < 0) begin
      shifted = '0;
    end
    code_next = CODE_W'(udiv(ALT_W'(shifted), ALT_W'(CODE_FT))) - CODE_W'(BIAS_CODES);
  end

  always_comb begin
    armed_next = armed_reg;
    hold_next  = 32'h0000_0000;
    clear_fire = 1'b0;
    if (up_program) begin
      armed_next = 1'b1;
    end
    if (armed_reg && down_hold) begin
      hold_next = hold_reg + 32'h0000_0001;
      if (hold_reg == 32'(CLR_CYC_P - 1)) begin
        clear_fire = 1'b1;
        armed_next = 1'b0;
        hold_next  = 32'h0000_0000;
      end
    end
  end

  always_comb begin
    curve_next = curve_reg;
    if (clear_fire) begin
      for (int i = 0; i < N_MARKS; i++) begin
        curve_next[i] = '0;
      end
    end else if (set_en) begin
      curve_next[set_idx] = clip_corr(mark_ft(set_idx) - press_alt_ft);
    end else if (program_trigger) begin
      curve_next[prog_alt_kft] = clip_corr(mark_ft(prog_alt_kft) - press_alt_ft);
    end
  end

  always_comb begin
    busy_next = busy_reg;
    kind_next = kind_reg;
    idx_next  = idx_reg;
    snap_next = snap_reg;
    take      = 1'b0;
    if (busy_reg) begin
      if (tx_rdy) begin
        idx_next = idx_reg + 9'h001;
        if (idx_reg == msg_len(kind_reg) - 9'h001) begin
          busy_next = 1'b0;
        end
      end
    end else if (req_reg) begin
      take      = 1'b1;
      busy_next = 1'b1;
      kind_next = req_kind_reg;
      idx_next  = 9'h000;
      snap_next = (req_kind_reg == MSG_ECHO) ? echo_reg : corr_alt;
    end else if (mode_reg == MODE_STREAM) begin
      busy_next = 1'b1;
      kind_next = MSG_STREAM;
      idx_next  = 9'h000;
      snap_next = corr_alt;
    end
  end

  always_comb begin
    mode_next     = mode_reg;
    buf_next      = buf_reg;
    len_next      = len_reg;
    q_last_next   = q_last_reg;
    req_next      = take ? 1'b0 : req_reg;
    req_kind_next = req_kind_reg;
    echo_next     = echo_reg;
    set_en        = 1'b0;
    set_num       = 7'(buf_reg[1] - CH_ZERO);
    if (len_reg == 3'h3) begin
      set_num = 7'(set_num * 7'(RADIX)) + 7'(buf_reg[2] - CH_ZERO);
    end
    set_idx = set_num[4:0];
    if (rx_vld) begin
      if (rx_byte == CH_Q) begin
        len_next    = 3'h0;
        q_last_next = 1'b1;
        if (q_last_reg) begin
          mode_next = MODE_STREAM;
        end
      end else if (rx_byte == CH_CR) begin
        q_last_next   = 1'b0;
        len_next      = 3'h0;
        mode_next     = MODE_CMD;
        req_next      = 1'b1;
        req_kind_next = MSG_PROMPT;
        if (len_reg == 3'h3 && buf_reg[0] == CH_A && buf_reg[1] == CH_D
            && buf_reg[2] == CH_J) begin
          req_kind_next = MSG_CORR;
        end else if (len_reg == 3'h1 && buf_reg[0] == CH_D) begin
          req_kind_next = MSG_DUMP;
        end else if (buf_reg[0] == CH_S && is_dig(buf_reg[1])
                     && (len_reg == 3'h2 || (len_reg == 3'h3 && is_dig(buf_reg[2])))
                     && set_num < N_MARKS) begin
          set_en        = 1'b1;
          req_kind_next = MSG_ECHO;
          echo_next     = ALT_W'(mark_ft(set_idx));
        end
      end else begin
        q_last_next = 1'b0;
        if (len_reg < 3'h3) begin
          buf_next[len_reg[1:0]] = rx_byte;
        end
        if (len_reg < 3'h4) begin
          len_next = len_reg + 3'h1;
        end
      end
    end
  end

  // Character generator; digits of the snapshot are formed as they are sent.
  always_comb begin
    s_abs = (snap_reg < 0) ? ALT_W'(-snap_reg) : ALT_W'(snap_reg);
    ent   = idx_reg[7:3];
    j     = (kind_reg == MSG_PROMPT) ? idx_reg - 9'h002 : idx_reg;
    e_abs = (curve_reg[ent] < 0) ? ALT_W'(-curve_reg[ent]) : ALT_W'(curve_reg[ent]);
    tx_ch = CH_CR;
    unique case (kind_reg)
      MSG_STREAM, MSG_PROMPT: begin
        if (kind_reg == MSG_PROMPT && idx_reg == 9'h000) begin
          tx_ch = CH_QM;
        end else if (kind_reg == MSG_PROMPT && idx_reg == 9'h001) begin
          tx_ch = CH_GT;
        end else if (j == 9'h000) begin
          tx_ch = (snap_reg < 0) ? CH_MINUS : CH_SP;
        end else if (j < 9'h005) begin
          tx_ch = dig_ch(s_abs, 3'(9'h005 - j));
        end else if (j == 9'h005) begin
          tx_ch = CH_ZERO;
        end
      end
      MSG_CORR: tx_ch = (idx_reg == 9'h000) ? CH_A : CH_EQ;
      MSG_ECHO: begin
        if (idx_reg == 9'h000) begin
          tx_ch = CH_GT;
        end else if (idx_reg < 9'h006) begin
          tx_ch = dig_ch(s_abs, 3'(9'h005 - idx_reg));
        end
      end
      MSG_DUMP: if (!idx_reg[8]) begin
        unique case (idx_reg[2:0])
          3'h0:    tx_ch = dig_ch(ALT_W'(ent) + ALT_W'(1), 3'h1);
          3'h1:    tx_ch = dig_ch(ALT_W'(ent) + ALT_W'(1), 3'h0);
          3'h2:    tx_ch = CH_EQ;
          3'h3:    tx_ch = (curve_reg[ent] < 0) ? CH_MINUS : CH_SP;
          3'h7:    tx_ch = CH_SP;
          default: tx_ch = dig_ch(e_abs, 3'(3'h6 - idx_reg[2:0]));
        endcase
      end
    endcase
  end

  // The curve has no reset so its contents outlive a reset.
  always_ff @(posedge clk) begin
    curve_reg <= curve_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      armed_reg    <= 1'b0;
      hold_reg     <= 32'h0000_0000;
      mode_reg     <= MODE_STREAM;
      buf_reg      <= '{default: 8'h00};
      len_reg      <= 3'h0;
      q_last_reg   <= 1'b0;
      req_reg      <= 1'b0;
      req_kind_reg <= MSG_PROMPT;
      echo_reg     <= '0;
      busy_reg     <= 1'b0;
      kind_reg     <= MSG_STREAM;
      idx_reg      <= 9'h000;
      snap_reg     <= '0;
      code_reg     <= '0;
    end else begin
      armed_reg    <= armed_next;
      hold_reg     <= hold_next;
      mode_reg     <= mode_next;
      buf_reg      <= buf_next;
      len_reg      <= len_next;
      q_last_reg   <= q_last_next;
      req_reg      <= req_next;
      req_kind_reg <= req_kind_next;
      echo_reg     <= echo_next;
      busy_reg     <= busy_next;
      kind_reg     <= kind_next;
      idx_reg      <= idx_next;
      snap_reg     <= snap_next;
      code_reg     <= code_next;
    end
  end

  assign par_alt_code = code_reg;
  assign cmd_mode     = (mode_reg == MODE_CMD);
endmodule

// ### design/acp_pkg.sv
// Shared constants and types of the altitude correction command port.
package acp_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int BAUD           = 9600;
  localparam int BIT_CYC        = CLK_HZ / BAUD;
  localparam int CLR_HOLD_S     = 2;
  localparam int CLR_CYC        = CLK_HZ * CLR_HOLD_S;
  localparam int ALT_W          = 17;
  localparam int CORR_W         = 11;
  localparam int CODE_W         = 11;
  localparam int N_MARKS        = 32;
  localparam int MARK_FT        = 1000;
  localparam int LOW_MARK_FT    = 0;
  localparam int TRANS_LEAD_FT  = 50;
  localparam int CODE_FT        = 100;
  localparam int CORR_MAX       = 999;
  localparam int BIAS_FT        = 2000;
  localparam int BIAS_CODES     = BIAS_FT / CODE_FT;
  localparam int RADIX          = 10;
  localparam int LEN_STREAM     = 7;
  localparam int LEN_PROMPT     = 9;
  localparam int LEN_CORR       = 2;
  localparam int LEN_ECHO       = 7;
  localparam int LEN_DUMP       = N_MARKS * 8 + 1;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_GT    = 8'h3E;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_J     = 8'h4A;
  localparam logic [7:0] CH_Q     = 8'h51;
  localparam logic [7:0] CH_S     = 8'h53;
  typedef enum logic [2:0] {MSG_STREAM, MSG_PROMPT, MSG_CORR, MSG_ECHO, MSG_DUMP} acp_msg_t;
  typedef enum logic {MODE_STREAM, MODE_CMD} acp_mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} acp_rx_t;
endpackage

// ### design/acp_uart.sv
// Serial byte receiver and transmitter, eight data bits, no parity, one stop bit.
`timescale 1ns/1ps
module acp_uart
  import acp_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rx,
  output logic            tx,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  localparam logic [15:0] FULL = 16'(BIT_CYC_P - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC_P / 2 - 1);

  acp_rx_t     rx_st_reg, rx_st_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0]  rx_bit_reg, rx_bit_next;
  logic [7:0]  rx_sh_reg, rx_sh_next;
  logic        rx_vld_reg, rx_vld_next;
  logic [9:0]  tx_sh_reg, tx_sh_next;
  logic [3:0]  tx_left_reg, tx_left_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;

  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_cnt_next = rx_cnt_reg + 16'h0001;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_vld_next = 1'b0;
    unique case (rx_st_reg)
      RX_IDLE: begin
        rx_cnt_next = 16'h0000;
        if (!rx) begin
          rx_st_next = RX_START;
        end
      end
      RX_START: if (rx_cnt_reg == HALF) begin
        rx_cnt_next = 16'h0000;
        rx_bit_next = 3'h0;
        rx_st_next  = rx ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cnt_reg == FULL) begin
        rx_cnt_next = 16'h0000;
        rx_sh_next  = {rx, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 3'h1;
        if (rx_bit_reg == 3'h7) begin
          rx_st_next = RX_STOP;
        end
      end
      RX_STOP: if (rx_cnt_reg == FULL) begin
        rx_st_next  = RX_IDLE;
        rx_vld_next = rx;
      end
    endcase
  end

  always_comb begin
    tx_sh_next   = tx_sh_reg;
    tx_left_next = tx_left_reg;
    tx_cnt_next  = tx_cnt_reg + 16'h0001;
    if (tx_left_reg == 4'h0) begin
      tx_cnt_next = 16'h0000;
      if (tx_valid) begin
        tx_sh_next   = {1'b1, tx_data, 1'b0};
        tx_left_next = 4'hA;
      end
    end else if (tx_cnt_reg == FULL) begin
      tx_cnt_next  = 16'h0000;
      tx_sh_next   = {1'b1, tx_sh_reg[9:1]};
      tx_left_next = tx_left_reg - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_reg   <= RX_IDLE;
      rx_cnt_reg  <= 16'h0000;
      rx_bit_reg  <= 3'h0;
      rx_sh_reg   <= 8'h00;
      rx_vld_reg  <= 1'b0;
      tx_sh_reg   <= 10'h3FF;
      tx_left_reg <= 4'h0;
      tx_cnt_reg  <= 16'h0000;
    end else begin
      rx_st_reg   <= rx_st_next;
      rx_cnt_reg  <= rx_cnt_next;
      rx_bit_reg  <= rx_bit_next;
      rx_sh_reg   <= rx_sh_next;
      rx_vld_reg  <= rx_vld_next;
      tx_sh_reg   <= tx_sh_next;
      tx_left_reg <= tx_left_next;
      tx_cnt_reg  <= tx_cnt_next;
    end
  end

  assign tx       = tx_sh_reg[0];
  assign tx_ready = (tx_left_reg == 4'h0);
  assign rx_data  = rx_sh_reg;
  assign rx_valid = rx_vld_reg;
endmodule

// ### testbench/acp_top_props.sv
// Port-level assertions of the altitude correction command port.
`timescale 1ns/1ps
module acp_top_props
  import acp_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int CLR_CYC_P = CLR_CYC
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    ser_rx,
  input wire logic                    ser_tx,
  input wire logic signed [ALT_W-1:0] press_alt_ft,
  input wire logic                    program_trigger,
  input wire logic [4:0]              prog_alt_kft,
  input wire logic                    up_program,
  input wire logic                    down_hold,
  input wire logic signed [CODE_W-1:0] par_alt_code,
  input wire logic                    cmd_mode
);
  logic prev_reg;
  int   run_reg;
  logic armed_reg;
  int   hold_reg;
  logic clean_set;
  // The clean flag survives reset, as the curve does, and drops on any write path.
  logic clean_reg = 1'b0;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  function automatic int code_of(input int alt);
    int v;
    v = alt + TRANS_LEAD_FT;
    v = (v < 0) ? -((CODE_FT - 1 - v) / CODE_FT) : v / CODE_FT;
    return (v < -BIAS_CODES) ? -BIAS_CODES : v;
  endfunction

  assign clean_set = armed_reg && down_hold && hold_reg == CLR_CYC_P - 1;

  always_ff @(posedge clk) begin
    prev_reg  <= rst ? 1'b1 : ser_tx;
    run_reg   <= (rst || ser_tx != prev_reg) ? 1 : run_reg + 1;
    armed_reg <= !rst && !clean_set && (armed_reg || up_program);
    hold_reg  <= (!rst && armed_reg && down_hold && !clean_set) ? hold_reg + 1 : 0;
    clean_reg <= clean_set || (clean_reg && !program_trigger && ser_rx);
  end

  sequence s_trig;
    program_trigger && press_alt_ft >= 0 && (press_alt_ft + 500) / 1000 == prog_alt_kft;
  endsequence
  sequence s_hold;
    $stable(press_alt_ft) [*2];
  endsequence
  property p_code(cond);
    cond && $stable(press_alt_ft) && !$past(rst) && !$past(rst, 2)
      |=> par_alt_code == code_of($past(press_alt_ft));
  endproperty

  AST_RESET_IDLE: assert property ($fell(rst) |-> ser_tx && !cmd_mode && par_alt_code == 0)
    else $error("outputs not idle after reset");
  AST_TX_BIT_RUN: assert property (ser_tx && !prev_reg |-> run_reg % BIT_CYC_P == 0)
    else $error("serial low run not whole bits");
  AST_TX_LOW_MAX: assert property (!ser_tx && !prev_reg |-> run_reg < 9 * BIT_CYC_P)
    else $error("serial low run too long");
  AST_CODE_NEG: assert property (p_code(press_alt_ft < 0))
    else $error("parallel code wrong below zero");
  AST_CODE_CLEAN: assert property (p_code(clean_reg))
    else $error("parallel code wrong on cleared curve");
  AST_TRIG_APPLY: assert property (s_trig ##1 s_hold |=> par_alt_code == $past(prog_alt_kft, 3) * 10)
    else $error("trigger correction not applied");
  AST_MODE_ENTER: assert property ($rose(cmd_mode) |-> ser_rx && $past(ser_rx))
    else $error("command mode entered mid byte");
  AST_MODE_EXIT: assert property ($fell(cmd_mode) |-> ser_rx && $past(ser_rx))
    else $error("command mode left mid byte");
endmodule

bind acp_top acp_top_props #(.BIT_CYC_P(BIT_CYC_P), .CLR_CYC_P(CLR_CYC_P)) props (
  .clk(clk), .rst(rst), .ser_rx(ser_rx), .ser_tx(ser_tx), .press_alt_ft(press_alt_ft),
  .program_trigger(program_trigger), .prog_alt_kft(prog_alt_kft), .up_program(up_program),
  .down_hold(down_hold), .par_alt_code(par_alt_code), .cmd_mode(cmd_mode)
);

// ### testbench/acp_term.sv
// Serial terminal model that sends command bytes and collects reply bytes.
`timescale 1ns/1ps
module acp_term #(
  parameter int BIT_CYC_P = 16
) (
  input  wire logic clk,
  input  wire logic ser_tx,
  output logic      ser_rx
);
  logic [7:0] rxq[$];
  int         frame_err = 0;
  logic [7:0] sh;

  initial ser_rx = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      ser_rx = f[i];
      repeat (BIT_CYC_P - 1) @(negedge clk);
    end
  endtask

  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
  endtask

  // Samples each bit in its middle, least significant bit first.
  always begin
    @(posedge clk);
    if (ser_tx === 1'b0) begin
      repeat (BIT_CYC_P / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC_P) @(posedge clk);
        sh[i] = ser_tx;
      end
      repeat (BIT_CYC_P) @(posedge clk);
      if (ser_tx !== 1'b1) frame_err++;
      rxq.push_back(sh);
    end
  end
endmodule

// ### testbench/acp_top_tb.sv
// Self-checking bench for the altitude correction command port.
`timescale 1ns/1ps
module acp_top_tb;
  import acp_pkg::*;
  localparam int BP = 16;
  localparam int CP = 20;
  logic                     clk = 1'b0;
  logic                     rst;
  logic                     ser_rx;
  logic                     ser_tx;
  logic signed [ALT_W-1:0]  press_alt_ft;
  logic                     program_trigger;
  logic [4:0]               prog_alt_kft;
  logic                     up_program;
  logic                     down_hold;
  logic signed [CODE_W-1:0] par_alt_code;
  logic                     cmd_mode;
  int                       failures = 0;
  int                       num_checks = 0;
  int                       a;
  int                       corner[6] = '{950, 949, 0, -50, -51, -2200};

  always #10 clk = ~clk;

  acp_top #(.BIT_CYC_P(BP), .CLR_CYC_P(CP)) dut (
    .clk(clk), .rst(rst), .ser_rx(ser_rx), .ser_tx(ser_tx), .press_alt_ft(press_alt_ft),
    .program_trigger(program_trigger), .prog_alt_kft(prog_alt_kft), .up_program(up_program),
    .down_hold(down_hold), .par_alt_code(par_alt_code), .cmd_mode(cmd_mode)
  );
  acp_term #(.BIT_CYC_P(BP)) term (.clk(clk), .ser_tx(ser_tx), .ser_rx(ser_rx));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic timeout(input string msg);
    failures++;
    $display("Error at %0t: %s timed out", $time, msg);
    report_and_stop();
  endtask

  function automatic int exp_code(input int alt);
    int v;
    v = alt + TRANS_LEAD_FT;
    v = (v < 0) ? -((CODE_FT - 1 - v) / CODE_FT) : v / CODE_FT;
    return (v < -BIAS_CODES) ? -BIAS_CODES : v;
  endfunction

  // Streamed altitude: sign, tens of feet as four digits, a zero, then a terminator.
  function automatic string fmt_alt(input int alt);
    int m;
    m = (alt < 0) ? -alt : alt;
    return $sformatf("%s%04d0\r", (alt < 0) ? "-" : " ", m / 10 % 10000);
  endfunction

  task automatic chk_alt(input int alt, input int corr);
    @(negedge clk);
    press_alt_ft = alt;
    repeat (3) @(negedge clk);
    check(par_alt_code, exp_code(alt + corr), "parallel code");
  endtask

  task automatic trig(input int alt, input int k);
    @(negedge clk);
    press_alt_ft = alt;
    prog_alt_kft = k;
    program_trigger = 1'b1;
    @(negedge clk);
    program_trigger = 1'b0;
  endtask

  task automatic clear_seq(input int n);
    @(negedge clk);
    up_program = 1'b1;
    @(negedge clk);
    up_program = 1'b0;
    down_hold = 1'b1;
    repeat (n) @(negedge clk);
    down_hold = 1'b0;
  endtask

  task automatic get_byte(output logic [7:0] b);
    int t;
    t = 0;
    while (term.rxq.size() == 0 && t < 200 * BP) begin
      @(negedge clk);
      t++;
    end
    if (term.rxq.size() == 0) begin
      timeout("serial reply");
    end else begin
      b = term.rxq.pop_front();
    end
  endtask

  task automatic expect_str(input string s);
    logic [7:0] b;
    int         k;
    b = 8'h00;
    k = 0;
    while (b != s[0] && k < 400) begin
      get_byte(b);
      k++;
    end
    check(b, s[0], "reply start");
    for (int i = 1; i < s.len(); i++) begin
      get_byte(b);
      check(b, s[i], "reply text");
    end
  endtask

  task automatic cmd(input string c, input string r);
    term.rxq.delete();
    term.send_str(c);
    expect_str(r);
  endtask

  task automatic stream_chk(input int alt, input int shown);
    @(negedge clk);
    press_alt_ft = alt;
    repeat (14 * 10 * BP) @(negedge clk);
    term.rxq.delete();
    expect_str(fmt_alt(shown));
  endtask

  initial begin
    rst = 1'b1;
    press_alt_ft = '0;
    program_trigger = 1'b0;
    prog_alt_kft = '0;
    up_program = 1'b0;
    down_hold = 1'b0;
    a = $urandom(73);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(ser_tx, 1'b1, "idle line");
    check(cmd_mode, 1'b0, "mode after reset");
    clear_seq(CP + 2);
    foreach (corner[i]) chk_alt(corner[i], 0);
    for (int i = 0; i < 20; i++) chk_alt(int'($urandom_range(31000)) - 2000, 0);
    a = int'($urandom_range(29000));
    stream_chk(12345, 12345);
    stream_chk(-1237, -1237);
    stream_chk(a, a);
    trig(10080, 10);
    chk_alt(10080, -80);
    chk_alt(10029, -80);
    chk_alt(10030, -80);
    chk_alt(9499, 0);
    trig(60, 0);
    chk_alt(60, -60);
    // The line is quiet in command mode, so the reset cuts no frame.
    cmd("\r", {"?>", fmt_alt(0)});
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_alt(10030, -80);
    clear_seq(CP - 3);
    chk_alt(10030, -80);
    cmd("\r", {"?>", fmt_alt(9950)});
    check(cmd_mode, 1'b1, "command mode");
    cmd({"AD", "J\r"}, "A=");
    cmd("ADQJ\r", "?>");
    cmd({"S", "32\r"}, "?>");
    term.send_str("QQ");
    a = 0;
    while (cmd_mode !== 1'b0 && a < 40 * BP) begin
      @(negedge clk);
      a++;
    end
    if (cmd_mode !== 1'b0) timeout("mode exit");
    check(cmd_mode, 1'b0, "streaming mode");
    stream_chk(10030, 9950);
    cmd({"S", "10\r"}, ">10000\r");
    chk_alt(10100, -30);
    cmd("D\r", "01=-060 02= 000 ");
    clear_seq(CP + 2);
    chk_alt(10060, 0);
    check(term.frame_err, 0, "framing");
    report_and_stop();
  end
endmodule
